// file: common/cop_consts.svh
/*
 Constants for the coprocessor channel port: request-type codes, option width,
 trap cause codes and status bit positions. Assumes inclusion by bare name.
*/
`ifndef COP_CONSTS_SVH
`define COP_CONSTS_SVH
`define REQ_STORE 2'h2
`define REQ_STORE_START 2'h3
`define REQ_LOAD 2'h2
`define REQ_LOAD_NOERR 2'h3
`define OPT_W 3
`define TRAP_NONE 2'h0
`define TRAP_NOT_PRESENT 2'h1
`define TRAP_COP_EXCEPTION 2'h2
`define STAT_BUSY 0
`define STAT_MASK_INT 1
`define STAT_MASK_ALL 2
`define STAT_SUPER 3
`define STAT_W 4
`define STAT_RESET 4'h8
`endif

// file: common/cop_pkg.sv
/*
 Types shared by both ends of the coprocessor channel port.
 Assumes the constants header is on the include path.
*/
`include "cop_consts.svh"
package cop_pkg;
  typedef logic [1:0] trap_t; // Trap cause code
  typedef logic [`STAT_W-1:0] status_t; // Processor status word
endpackage : cop_pkg

// file: common/cop_channel_if.sv
/*
 Channel wires between the processor end and the coprocessor end.
 Assumes both ends share core_clk; active-low strobes as on the channel.
*/
`timescale 1ns/1ps
interface cop_channel_if;
  logic [31:0] addr_bus; // Address bus, carries operand A on stores
  logic [31:0] data_bus_out; // Processor-driven data
  logic [31:0] data_bus_in; // Coprocessor-driven data
  logic read_not_write; // 1 load, 0 store
  logic helper_select; // High only for coprocessor transfers
  logic request_qualifier; // Start / suppress-errors qualifier
  logic data_request_n; // Request strobe
  logic bus_invalid_n; // Low when the address bus is not valid
  logic [2:0] transfer_kind_lines; // Option field
  logic supervisor_not_user; // 1 supervisor, 0 user
  logic helper_accept_n; // Coprocessor can take transfers
  logic data_ready_n; // Load data valid
  logic data_error_n; // Coprocessor exception
  modport proc
  (
    output addr_bus, data_bus_out, read_not_write, helper_select, request_qualifier,
    output data_request_n, bus_invalid_n, transfer_kind_lines, supervisor_not_user,
    input data_bus_in, helper_accept_n, data_ready_n, data_error_n
  );
  modport cop
  (
    input addr_bus, data_bus_out, read_not_write, helper_select, request_qualifier,
    input data_request_n, bus_invalid_n, transfer_kind_lines, supervisor_not_user,
    output data_bus_in, helper_accept_n, data_ready_n, data_error_n
  );
endinterface : cop_channel_if

// file: verilog/cop_proc_end.sv
/*
 Processor end of the coprocessor channel: issues coprocessor loads and
 stores, keeps the busy flag and mask bits, reports traps.
 Assumes instructions arrive on a valid/ready port and the trap handler
 acknowledges traps by the next instruction.
*/
// Behaviour
// - Absent unit makes transfers trap instead.
// - Keep channel registers holding the trapped transfer; an error on a non-last burst beat still steps the address.
// - Set-active store sets busy; load clears.
// - Copy busy flag into old status on traps.
// - Only supervisor may change mask bits.
// - Stores drive both buses in one cycle.
// - Loads move one word on data bus.
// - Select high; qualifier encodes start or suppress.
// - Select low whenever address bus idle.
// - Coprocessor decodes from select and invalid only.
// - Coprocessor holds accept off when busy.
// - Accept completes stores; data-ready completes loads.
// - Other devices ignore addresses while select high.
// - Option field driven on option lines.
// - Stores use write, loads read protocol.
// - Loads still drive address from instruction.
// - Data error raises coprocessor exception trap.
// - Bursts carry one word per beat, address increments.
// - Coprocessor drops accept during its operation.
// - No store completes while accept inactive.
// - Coprocessor skips error when suppressing.
// - Coprocessor should hold accept steadily.
// - Qualifier from instruction; user bit forces user.
`timescale 1ns/1ps
`include "cop_consts.svh"
module cop_proc_end
  import cop_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  cop_channel_if.proc ch,
  input wire logic unit_present_bit,
  input wire logic ins_valid,
  output logic ins_ready,
  input wire logic ins_load,
  input wire logic [31:0] ins_op_a,
  input wire logic [31:0] ins_op_b,
  input wire logic [3:0] ins_count,
  input wire logic transfer_qualifier_bit,
  input wire logic set_active_bit,
  input wire logic user_emulation_bit,
  input wire logic [`OPT_W-1:0] ins_option,
  input wire logic status_wr,
  input wire logic [`STAT_W-1:0] status_wdata,
  output logic [`STAT_W-1:0] status,
  output logic [`STAT_W-1:0] old_status,
  output logic [1:0] trap_cause,
  output logic trap_pulse,
  output logic [31:0] load_data,
  output logic load_valid,
  output logic [31:0] chan_addr,
  output logic [31:0] chan_data,
  output logic [9:0] chan_ctrl
);
  typedef enum {IDLE, XFER} state_e;
  state_e state_r;
  status_t status_r;
  status_t old_status_r;
  trap_t trap_r;
  logic trap_pulse_r;
  logic [31:0] addr_r; // Channel address register
  logic [31:0] data_r; // Channel data register
  logic [9:0] ctrl_r; // Channel control register
  logic [3:0] beats_r; // Remaining burst beats minus one
  logic load_r;
  logic qual_r;
  logic user_r;
  logic [`OPT_W-1:0] opt_r;
  logic [31:0] load_data_r;
  logic load_valid_r;

  // Decode of a new instruction and completion of the current beat
  wire take = (state_r == IDLE) && ins_valid;
  wire absent = take && !unit_present_bit;
  wire issue = take && unit_present_bit;
  wire store_done = (state_r == XFER) && !load_r && !ch.helper_accept_n;
  wire load_done = (state_r == XFER) && load_r && !ch.data_ready_n;
  wire beat_done = store_done || load_done;
  wire err_hit = beat_done && !ch.data_error_n;
  wire last_beat = beat_done && (beats_r == 4'h0);
  wire is_super = status_r[`STAT_SUPER];
  wire take_trap = absent || err_hit;
  wire [9:0] ctrl_nxt = {ins_count, ins_load, transfer_qualifier_bit, set_active_bit,
    ins_option};

  assign ins_ready = (state_r == IDLE);
  // Channel outputs; select defaults low when idle
  assign ch.helper_select = (state_r == XFER);
  assign ch.request_qualifier = qual_r;
  assign ch.read_not_write = load_r;
  assign ch.data_request_n = (state_r != XFER);
  assign ch.bus_invalid_n = (state_r == XFER);
  assign ch.addr_bus = addr_r;
  assign ch.data_bus_out = data_r;
  assign ch.transfer_kind_lines = opt_r;
  assign ch.supervisor_not_user = is_super && !user_r;
  assign status = status_r;
  assign old_status = old_status_r;
  assign trap_cause = trap_r;
  assign trap_pulse = trap_pulse_r;
  assign load_data = load_data_r;
  assign load_valid = load_valid_r;
  assign chan_addr = addr_r;
  assign chan_data = data_r;
  assign chan_ctrl = ctrl_r;

  // Transfer sequencer; stores use the write protocol, loads the read protocol
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= IDLE;
      beats_r <= 4'h0;
    end
    else
    begin
      case (state_r)
        IDLE:
        begin
          if (issue)
          begin
            state_r <= XFER;
            beats_r <= ins_count;
          end
        end
        XFER:
        begin
          // An error ends the burst at once; after a non-last beat the handler sees the next beat's address
          if (last_beat || err_hit)
            state_r <= IDLE;
          else if (beat_done)
            beats_r <= beats_r - 4'h1;
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // Channel registers; loaded on every take so a trap leaves them in place, except the address after an error on a non-last burst beat
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_r <= 32'h0;
      data_r <= 32'h0;
      ctrl_r <= 10'h0;
      load_r <= 1'b0;
      qual_r <= 1'b0;
      user_r <= 1'b0;
      opt_r <= '0;
    end
    else if (take)
    begin
      addr_r <= ins_load ? ins_op_b : ins_op_a;
      data_r <= ins_load ? 32'h0 : ins_op_b;
      ctrl_r <= ctrl_nxt;
      load_r <= ins_load;
      qual_r <= transfer_qualifier_bit;
      user_r <= user_emulation_bit;
      opt_r <= ins_option;
    end
    else if (beat_done && !last_beat)
    begin
      // Burst: address increments by one word, one word per beat
      addr_r <= addr_r + 32'h4;
    end
  end

  // Load capture, one word per beat from the data bus
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_data_r <= 32'h0;
      load_valid_r <= 1'b0;
    end
    else
    begin
      load_valid_r <= load_done;
      if (load_done)
        load_data_r <= ch.data_bus_in;
    end
  end

  // Status word: busy flag, masks, old status on trap
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_r <= `STAT_RESET;
      old_status_r <= `STAT_RESET;
      trap_r <= `TRAP_NONE;
      trap_pulse_r <= 1'b0;
    end
    else
    begin
      trap_pulse_r <= take_trap;
      if (take_trap)
      begin
        old_status_r <= status_r;
        trap_r <= absent ? `TRAP_NOT_PRESENT : `TRAP_COP_EXCEPTION;
        status_r[`STAT_SUPER] <= 1'b1;
      end
      else if (status_wr && is_super)
      begin
        // User code cannot change the masks; writes are dropped
        status_r[`STAT_MASK_INT] <= status_wdata[`STAT_MASK_INT];
        status_r[`STAT_MASK_ALL] <= status_wdata[`STAT_MASK_ALL];
        status_r[`STAT_SUPER] <= status_wdata[`STAT_SUPER];
      end
      // Busy flag changes when the transfer is issued, never on absent trap
      if (issue && set_active_bit)
        status_r[`STAT_BUSY] <= !ins_load;
    end
  end
endmodule : cop_proc_end

// file: verilog/cop_unit_end.sv
/*
 Coprocessor end: takes stores from select and invalid, runs an operation
 for a fixed count with accept off, returns words on loads.
 Assumes the processor end drives the channel on core_clk.
*/
`timescale 1ns/1ps
`include "cop_consts.svh"
module cop_unit_end
  import cop_pkg::*;
#(
  parameter int OP_CYCLES = 4
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  cop_channel_if.cop ch,
  input wire logic raise_error,
  output logic [63:0] operand,
  output logic operand_valid,
  output logic [2:0] operand_kind,
  output logic busy
);
  logic [7:0] count_r; // Operation cycles remaining
  logic [31:0] result_r; // Last result
  logic [63:0] operand_r;
  logic operand_valid_r;
  logic [2:0] kind_r;
  logic rdy_n_r;

  // Decode from select and invalid only
  wire hit = ch.helper_select && ch.bus_invalid_n;
  wire is_busy = (count_r != 8'h0);
  wire store_hit = hit && !ch.read_not_write && !is_busy;
  wire load_hit = hit && ch.read_not_write;
  wire start = store_hit && ch.request_qualifier;

  // Accept held steadily while idle, dropped for the operation
  assign ch.helper_accept_n = is_busy;
  assign ch.data_ready_n = !(load_hit && !rdy_n_r);
  assign ch.data_bus_in = result_r;
  // Error suppressed when the load asks for it
  assign ch.data_error_n = !(raise_error && hit && !(ch.read_not_write
    && ch.request_qualifier));
  assign operand = operand_r;
  assign operand_valid = operand_valid_r;
  assign operand_kind = kind_r;
  assign busy = is_busy;

  // Operation counter, operand capture, load ready pacing
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_r <= 8'h0;
      result_r <= 32'h0;
      operand_r <= 64'h0;
      operand_valid_r <= 1'b0;
      kind_r <= 3'h0;
      rdy_n_r <= 1'b0;
    end
    else
    begin
      operand_valid_r <= store_hit;
      // Ready in the same cycle as the request, then drop for a cycle
      rdy_n_r <= load_hit && !rdy_n_r;
      if (store_hit)
      begin
        operand_r <= {ch.addr_bus, ch.data_bus_out};
        kind_r <= ch.transfer_kind_lines;
      end
      if (start)
      begin
        count_r <= 8'(OP_CYCLES);
        result_r <= ch.addr_bus + ch.data_bus_out;
      end
      else if (is_busy)
        count_r <= count_r - 8'h1;
    end
  end
endmodule : cop_unit_end

// file: test/cop_channel_monitor.sv
/*
 Checker for the channel wires between the processor end and the unit end.
 Assumes it sits beside the channel interface and shares core_clk and rst_n.
*/
`timescale 1ns/1ps
module cop_channel_monitor
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] addr_bus,
  input wire logic [31:0] data_bus_out,
  input wire logic read_not_write,
  input wire logic helper_select,
  input wire logic request_qualifier,
  input wire logic data_request_n,
  input wire logic bus_invalid_n,
  input wire logic [2:0] transfer_kind_lines,
  input wire logic helper_accept_n,
  input wire logic data_ready_n,
  input wire logic data_error_n
);
  // One clock domain, so clock and reset are given once for all checks
  default clocking mon_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Completed beats; an error beat is left out since it ends the transfer
  wire st_beat = helper_select && !read_not_write && !helper_accept_n && data_error_n;
  wire ld_beat = helper_select && read_not_write && !data_ready_n && data_error_n;
  sel_idle_a: assert property (data_request_n |-> !helper_select)
    else $error("select high with no request");
  sel_valid_a: assert property (helper_select |-> bus_invalid_n)
    else $error("select high on an invalid bus");
  store_hold_a: assert property (helper_select && !read_not_write && helper_accept_n
    && data_error_n |=> helper_select && $stable(addr_bus) && $stable(data_bus_out))
    else $error("store moved while accept inactive");
  load_hold_a: assert property (helper_select && read_not_write && data_ready_n
    && data_error_n |=> helper_select && read_not_write && $stable(addr_bus))
    else $error("load ended without data ready");
  fields_hold_a: assert property (helper_select && $past(helper_select) |->
    $stable(request_qualifier) && $stable(read_not_write) && $stable(transfer_kind_lines))
    else $error("qualifier or option changed mid transfer");
  load_step_a: assert property (ld_beat ##1 helper_select |->
    addr_bus == $past(addr_bus) + 32'h4) else $error("burst load address did not step");
  store_end_a: assert property (st_beat |=> !helper_select ||
    addr_bus == $past(addr_bus) + 32'h4) else $error("accepted store still pending");
  err_end_a: assert property (helper_select && !data_error_n |=> !helper_select)
    else $error("transfer went on after data error");
endmodule : cop_channel_monitor

// file: test/tb_coprocessor_channel_port.sv
/*
 Testbench joining both ends of the coprocessor channel back to back.
 Assumes package, interface, design files and the checker are compiled first.
*/
`timescale 1ns/1ps
`include "cop_consts.svh"
// Counts one comparison and reports it when the values differ
`define CHK(nm, act, exp) begin tests_run++; if ((act) !== (exp)) begin err_count++; \
  $display("BAD %s expected %0h seen %0h", nm, exp, act); end end
module tb_coprocessor_channel_port
  import cop_pkg::*;
;
  logic core_clk = 1'b0, rst_n = 1'b0;
  logic unit_present_bit = 1'b1, ins_valid = 1'b0, ins_load = 1'b0, raise_error = 1'b0;
  logic [31:0] ins_op_a = 32'h0, ins_op_b = 32'h0;
  logic [3:0] ins_count = 4'h0;
  logic transfer_qualifier_bit = 1'b0, set_active_bit = 1'b0, user_emulation_bit = 1'b0;
  logic [2:0] ins_option = 3'h0;
  logic status_wr = 1'b0;
  logic [3:0] status_wdata = 4'h0;
  logic ins_ready, trap_pulse, load_valid, operand_valid, busy;
  status_t status, old_status;
  trap_t trap_cause;
  logic [31:0] load_data, chan_addr, chan_data, got;
  logic [9:0] chan_ctrl;
  logic [63:0] operand, last_op;
  logic [2:0] operand_kind, last_kind;
  logic seen_sel, sun, trapped; // What the last transfer showed
  int nval, stall, err_count = 0, tests_run = 0;
  always #2.5 core_clk = ~core_clk;
  cop_channel_if cop_channel_if_i ();
  cop_proc_end cop_proc_end_i (.core_clk, .rst_n, .ch(cop_channel_if_i), .unit_present_bit,
    .ins_valid, .ins_ready, .ins_load, .ins_op_a, .ins_op_b, .ins_count, .transfer_qualifier_bit,
    .set_active_bit, .user_emulation_bit, .ins_option, .status_wr, .status_wdata, .status,
    .old_status, .trap_cause, .trap_pulse, .load_data, .load_valid, .chan_addr, .chan_data,
    .chan_ctrl);
  // A long operation so that a store right behind it is sure to stall
  cop_unit_end #(.OP_CYCLES(8)) cop_unit_end_i (.core_clk, .rst_n, .ch(cop_channel_if_i),
    .raise_error, .operand, .operand_valid, .operand_kind, .busy);
  cop_channel_monitor cop_channel_monitor_i (.core_clk, .rst_n,
    .addr_bus(cop_channel_if_i.addr_bus), .data_bus_out(cop_channel_if_i.data_bus_out),
    .read_not_write(cop_channel_if_i.read_not_write),
    .helper_select(cop_channel_if_i.helper_select),
    .request_qualifier(cop_channel_if_i.request_qualifier),
    .data_request_n(cop_channel_if_i.data_request_n),
    .bus_invalid_n(cop_channel_if_i.bus_invalid_n),
    .transfer_kind_lines(cop_channel_if_i.transfer_kind_lines),
    .helper_accept_n(cop_channel_if_i.helper_accept_n),
    .data_ready_n(cop_channel_if_i.data_ready_n), .data_error_n(cop_channel_if_i.data_error_n));
  // Prints the verdict and ends the run
  task automatic wrap_up;
    if (err_count == 0 && tests_run > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // Issues one instruction, then watches until the channel is quiet for three cycles
  task automatic xfer(input logic ld, input logic [31:0] a, input logic [31:0] b,
    input logic [3:0] cnt, input logic qual, input logic set_act, input logic user_em,
    input logic [2:0] opt);
    int n;
    int q;
    q = 0;
    {ins_load, ins_op_a, ins_op_b, ins_count} = {ld, a, b, cnt};
    {transfer_qualifier_bit, set_active_bit, user_emulation_bit, ins_option} =
      {qual, set_act, user_em, opt};
    ins_valid = 1'b1;
    @(posedge core_clk);
    #1;
    ins_valid = 1'b0;
    {seen_sel, trapped, sun} = 3'h0;
    nval = 0;
    stall = 0;
    for (n = 0; n < 80 && q < 3; n++)
    begin
      if (cop_channel_if_i.helper_select === 1'b1)
      begin
        seen_sel = 1'b1;
        sun = cop_channel_if_i.supervisor_not_user;
        stall += (cop_channel_if_i.helper_accept_n === 1'b1 && !ld) ? 1 : 0;
      end
      trapped |= (trap_pulse === 1'b1);
      nval += (load_valid === 1'b1) ? 1 : 0;
      got = (load_valid === 1'b1) ? load_data : got;
      {last_op, last_kind} = (operand_valid === 1'b1) ? {operand, operand_kind} : {last_op, last_kind};
      q = (ins_ready === 1'b1 && cop_channel_if_i.helper_select === 1'b0) ? q + 1 : 0;
      @(posedge core_clk);
      #1;
    end
    `CHK("quiet", q, 3)
  endtask : xfer
  // Writes the status word and checks the mask and mode bits
  task automatic wr_status(input logic [3:0] v, input logic [2:0] exp);
    status_wr = 1'b1;
    status_wdata = v;
    @(posedge core_clk);
    #1;
    status_wr = 1'b0;
    `CHK("status_bits", status[3:1], exp)
    // Let an edge pass so a following write does not retoggle the strobe at once
    @(posedge core_clk);
    #1;
  endtask : wr_status
  // Guards against a hang; the whole sequence needs well under this span
  initial
  begin
    #20000;
    err_count++;
    wrap_up();
  end
  initial
  begin
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    `CHK("status_reset", status, 4'h8)
    `CHK("select_reset", cop_channel_if_i.helper_select, 1'b0)
    // Start store with user emulation and set-active
    xfer(1'b0, 32'h1234_5678, 32'h0000_0011, 4'h0, 1'b1, 1'b1, 1'b1, 3'h5);
    `CHK("operand", last_op, {32'h1234_5678, 32'h0000_0011})
    `CHK("kind", last_kind, 3'h5)
    `CHK("busy_set", status[0], 1'b1)
    `CHK("user_out", sun, 1'b0)
    // Plain store behind it must wait for accept
    xfer(1'b0, 32'h0000_00aa, 32'h0000_00bb, 4'h0, 1'b0, 1'b0, 1'b0, 3'h2);
    `CHK("stalled", stall > 0, 1'b1)
    `CHK("operand2", last_op, {32'h0000_00aa, 32'h0000_00bb})
    `CHK("super_out", sun, 1'b1)
    // Plain load of the result clears the busy flag
    xfer(1'b1, 32'h0, 32'h0000_0040, 4'h0, 1'b0, 1'b1, 1'b0, 3'h1);
    `CHK("result", got, 32'h1234_5689)
    `CHK("one_word", nval, 1)
    `CHK("busy_clr", status[0], 1'b0)
    // Suppressing burst load of three words
    xfer(1'b1, 32'h0, 32'h0000_0100, 4'h2, 1'b1, 1'b0, 1'b0, 3'h0);
    `CHK("burst_words", nval, 3)
    // Error on a load during an active operation
    xfer(1'b0, 32'h1, 32'h2, 4'h0, 1'b1, 1'b1, 1'b0, 3'h0);
    raise_error = 1'b1;
    xfer(1'b1, 32'h0, 32'h0, 4'h0, 1'b0, 1'b0, 1'b0, 3'h0);
    `CHK("err_trap", trapped, 1'b1)
    `CHK("err_cause", trap_cause, `TRAP_COP_EXCEPTION)
    `CHK("old_busy", old_status[0], 1'b1)
    // Suppressing load reads the result with no exception reported
    xfer(1'b1, 32'h0, 32'h0, 4'h0, 1'b1, 1'b0, 1'b0, 3'h0);
    raise_error = 1'b0;
    `CHK("err_quiet", trapped, 1'b0)
    `CHK("err_result", got, 32'h0000_0003)
    // Masks and mode change only from supervisor mode
    wr_status(4'hf, 3'h7);
    wr_status(4'h1, 3'h0);
    wr_status(4'hf, 3'h0);
    // Absent unit: set-active load traps and leaves busy alone
    unit_present_bit = 1'b0;
    xfer(1'b1, 32'h0, 32'h0000_0044, 4'h0, 1'b0, 1'b1, 1'b0, 3'h0);
    `CHK("np_trap", trapped, 1'b1)
    `CHK("np_cause", trap_cause, `TRAP_NOT_PRESENT)
    `CHK("np_silent", seen_sel, 1'b0)
    `CHK("np_busy", status[0], 1'b1)
    `CHK("np_old", old_status[0], 1'b1)
    // Absent unit: trapped store details stay for the handler
    xfer(1'b0, 32'hcafe_0001, 32'h0000_0077, 4'h0, 1'b1, 1'b0, 1'b0, 3'h6);
    `CHK("ch_addr", chan_addr, 32'hcafe_0001)
    `CHK("ch_data", chan_data, 32'h0000_0077)
    `CHK("ch_ctrl", chan_ctrl, {4'h0, 1'b0, 1'b1, 1'b0, 3'h6})
    wrap_up();
  end
endmodule : tb_coprocessor_channel_port
